// file: bts_core.sv
// Execution logic for the bit-test-and-skip instructions.
// Notes on behaviour
// - Skip next instruction when tested bit is zero (opcode 1011) or one (opcode 1010).
// - Skip discards fetched word, runs no-operation cycle.
// - Bank bit 0 access bank, 1 bank pointer.
// - Extended set, bank 0, field <=95: indexed.
// - Opcodes 1011 and 1010 with bit, bank, register fields.
`timescale 1ns/1ps
module bts_core (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr,
  input  wire logic [3:0]  bank_pointer_register,
  input  wire logic        ext_set_en,
  input  wire logic [7:0]  file_rd_data,
  input  wire logic [7:0]  index_base,
  output logic             file_rd,
  output logic [11:0]      file_addr,
  output logic             file_indexed,
  output logic             discard_fetch,
  output logic             nop_slot,
  output logic             busy,
  output logic             done
);
  typedef struct packed {
    bts_pkg::bts_state_t state;
    logic [1:0]          q;
    logic                want_set;
    logic [2:0]          bit_sel;
    bts_pkg::bts_req_t   req;
    logic                discard;
    logic                nop;
    logic                done;
    logic                busy;
  } bts_regs_t;

  bts_regs_t         r;
  bts_regs_t         next_r;
  bts_pkg::bts_dec_t dec;
  logic [11:0]       next_addr;
  logic              next_idx;
  logic              bit_val;

  bts_decode u_dec (
    .instr (instr),
    .dec   (dec)
  );

  always_comb begin
    next_idx  = 1'b0;
    next_addr = {bank_pointer_register, dec.reg_field};
    if (!dec.bank_sel) begin
      if (ext_set_en && dec.reg_field <= bts_pkg::IDX_OFFSET_MAX) begin
        next_idx  = 1'b1;
        next_addr = {4'h0, index_base + dec.reg_field};
      end else if (dec.reg_field < bts_pkg::ACCESS_SPLIT) begin
        next_addr = {4'h0, dec.reg_field};
      end else begin
        next_addr = {bts_pkg::ACCESS_HI_BANK, dec.reg_field};
      end
    end
  end

  assign bit_val = file_rd_data[r.bit_sel];

  // The cycle is four quarters; the test resolves in the third quarter
  // so the discard reaches the fetch unit before the next word runs.
  always_comb begin
    next_r      = r;
    next_r.q    = r.q + 2'h1;
    next_r.done = 1'b0;
    unique case (r.state)
      bts_pkg::BTS_IDLE: begin
        next_r.q = bts_pkg::Q_RESET;
        next_r.discard = 1'b0;
        next_r.nop = 1'b0;
        if (instr_valid && dec.is_test) begin
          next_r.state        = bts_pkg::BTS_EXECUTE;
          next_r.q            = 2'h1;
          next_r.want_set     = dec.want_set;
          next_r.bit_sel      = dec.bit_sel;
          next_r.req.rd       = 1'b1;
          next_r.req.addr     = next_addr;
          next_r.req.indexed  = next_idx;
        end
      end
      bts_pkg::BTS_EXECUTE: begin
        if (r.q == bts_pkg::Q_TEST) begin
          next_r.req.rd = 1'b0;
          if (bit_val == r.want_set) begin
            next_r.discard = 1'b1;
            next_r.nop     = 1'b1;
            next_r.state   = bts_pkg::BTS_SKIP;
          end
        end
        if (r.q == bts_pkg::Q_LAST && r.state == next_r.state) begin
          next_r.state = bts_pkg::BTS_IDLE;
          next_r.done  = 1'b1;
        end
      end
      bts_pkg::BTS_SKIP: begin
        next_r.discard = 1'b0;
        if (r.q == bts_pkg::Q_LAST && r.nop && !r.discard) begin
          next_r.state = bts_pkg::BTS_IDLE;
          next_r.nop   = 1'b0;
          next_r.done  = 1'b1;
        end
      end
      default: begin
        next_r.state = bts_pkg::BTS_IDLE;
      end
    endcase
    // Busy is kept in a flip-flop so the port carries no decode glitch.
    next_r.busy = (next_r.state != bts_pkg::BTS_IDLE);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    file_rd       = r.req.rd;
    file_addr     = r.req.addr;
    file_indexed  = r.req.indexed;
    discard_fetch = r.discard;
    nop_slot      = r.nop;
    busy          = r.busy;
    done          = r.done;
  end

  chk_skip_length: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(discard_fetch) |-> nop_slot [*5] ##[1:4] done)
    else $error("Skip slot length wrong.");
  chk_clear_skip: assert property (
    @(posedge clk_sys) disable iff (rst)
    (r.state == bts_pkg::BTS_EXECUTE && r.q == 2'h2 && !r.want_set &&
     !bit_val) |=> discard_fetch)
    else $error("Clear test did not skip.");
  chk_set_skip: assert property (
    @(posedge clk_sys) disable iff (rst)
    (r.state == bts_pkg::BTS_EXECUTE && r.q == 2'h2 && r.want_set &&
     bit_val) |=> discard_fetch)
    else $error("Set test did not skip.");
  chk_no_false: assert property (
    @(posedge clk_sys) disable iff (rst)
    (r.state == bts_pkg::BTS_EXECUTE && r.q == 2'h2 &&
     bit_val != r.want_set) |=> !discard_fetch ##1 done)
    else $error("Skip without condition.");
  chk_discard_pulse: assert property (
    @(posedge clk_sys) disable iff (rst)
    discard_fetch |=> !discard_fetch)
    else $error("Discard pulse too long.");
  // done is one pulse while idle.
  chk_done_pulse: assert property (
    @(posedge clk_sys) disable iff (rst)
    done |-> !busy ##1 !done)
    else $error("Done pulse wrong.");
  chk_opcode_start: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!busy && instr_valid && instr[15:12] == 4'hB) |=> busy && file_rd)
    else $error("Opcode not accepted.");
  chk_set_start: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!busy && instr_valid && instr[15:12] == 4'hA) |=> busy && file_rd)
    else $error("Set opcode not accepted.");
  chk_other_idle: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!busy && instr_valid && instr[15:13] != 3'h5) |=> !busy)
    else $error("Foreign opcode accepted.");
  chk_index_mode: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!busy && instr_valid && dec.is_test && !instr[8] && ext_set_en &&
     instr[7:0] <= 8'h5F) |=> file_indexed)
    else $error("Indexed mode missed.");
  // indexed address is base plus offset.
  chk_index_addr: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!busy && instr_valid && dec.is_test && !instr[8] && ext_set_en &&
     instr[7:0] <= 8'h5F) |=>
    file_addr == {4'h0, $past(index_base) + $past(instr[7:0])})
    else $error("Indexed address wrong.");
  chk_bank_ptr: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!busy && instr_valid && dec.is_test && instr[8]) |=>
    file_addr == {$past(bank_pointer_register), $past(instr[7:0])})
    else $error("Bank pointer address wrong.");
  chk_access_low: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!busy && instr_valid && dec.is_test && !instr[8] && !ext_set_en &&
     instr[7:0] < 8'h60) |=> file_addr[11:8] == 4'h0)
    else $error("Access bank address wrong.");
  chk_access_high: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!busy && instr_valid && dec.is_test && !instr[8] &&
     instr[7:0] >= 8'h60) |=> file_addr[11:8] == 4'hF)
    else $error("Access bank high address wrong.");

  cov_skip_clear: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(discard_fetch) && !r.want_set);
  cov_skip_set: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(discard_fetch) && r.want_set);
  cov_no_skip: cover property (@(posedge clk_sys) disable iff (rst)
    done && !nop_slot && !$past(nop_slot));
  cov_indexed: cover property (@(posedge clk_sys) disable iff (rst)
    file_rd && file_indexed);
endmodule : bts_core

// file: bts_core_test.sv
// Self-checking bench for the bit-test-skip execution block.
`timescale 1ns/1ps
module bts_core_test;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        instr_valid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [3:0]  bank_pointer_register = 4'h0;
  logic        ext_set_en = 1'b0;
  logic [7:0]  file_rd_data = 8'h00;
  logic [7:0]  index_base = 8'h00;
  logic        file_rd, file_indexed, discard_fetch, nop_slot, busy, done;
  logic [11:0] file_addr;
  int          errors = 0;
  int          n_checks = 0;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

  always #5 clk_sys = ~clk_sys;

  bts_core u_dut (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
    .instr(instr), .bank_pointer_register(bank_pointer_register),
    .ext_set_en(ext_set_en), .file_rd_data(file_rd_data),
    .index_base(index_base), .file_rd(file_rd), .file_addr(file_addr),
    .file_indexed(file_indexed), .discard_fetch(discard_fetch),
    .nop_slot(nop_slot), .busy(busy), .done(done));

  task finish_test;
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // A second word offered while busy must be ignored, so busy drops on time.
  task automatic run(input logic [3:0] opc, input logic [2:0] b,
    input logic a, input logic [7:0] f, input logic [3:0] bp,
    input logic ext, input logic [7:0] base, input logic [7:0] d,
    input logic [11:0] ea, input logic ei, input logic sk);
    int n;
    n = 0;
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr <= {opc, b, a, f};
    bank_pointer_register <= bp;
    ext_set_en <= ext;
    index_base <= base;
    file_rd_data <= d;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK(file_rd, 1'b1)
    `CHK(file_addr, ea)
    `CHK(file_indexed, ei)
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    #1;
    `CHK({discard_fetch, nop_slot}, {sk, sk})
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    `CHK({discard_fetch, nop_slot}, {1'b0, sk})
    while (done !== 1'b1 && n < 12) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 12) begin
      errors++;
      finish_test();
    end
    `CHK(n > 3, sk)
    @(posedge clk_sys);
    #1;
    `CHK({busy, nop_slot, discard_fetch}, 3'h0)
  endtask : run

  task t_clear_skip;
    run(bts_pkg::OPC_SKIP_CLEAR, 3'h7, 1'b1, 8'h12, 4'h3, 1'b0,
      8'h00, 8'h7F, 12'h312, 1'b0, 1'b1);
  endtask : t_clear_skip

  task t_clear_pass;
    run(bts_pkg::OPC_SKIP_CLEAR, 3'h0, 1'b0, 8'h5F, 4'h3, 1'b0,
      8'h00, 8'h01, 12'h05F, 1'b0, 1'b0);
  endtask : t_clear_pass

  task t_set_skip;
    run(bts_pkg::OPC_SKIP_SET, 3'h3, 1'b0, 8'h60, 4'h2, 1'b1,
      8'h10, 8'h08, 12'hF60, 1'b0, 1'b1);
  endtask : t_set_skip

  task t_set_indexed;
    run(bts_pkg::OPC_SKIP_SET, 3'h5, 1'b0, 8'h5F, 4'h2, 1'b1,
      8'hF0, 8'hDF, 12'h04F, 1'b1, 1'b0);
  endtask : t_set_indexed

  task t_set_top;
    run(bts_pkg::OPC_SKIP_SET, 3'h0, 1'b1, 8'hFF, 4'hF, 1'b1,
      8'h00, 8'hFF, 12'hFFF, 1'b0, 1'b1);
  endtask : t_set_top

  // Words outside the two opcodes must leave the block idle.
  task t_other_opcode;
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr <= 16'h8E12;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK({busy, file_rd, done}, 3'h0)
  endtask : t_other_opcode

  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    `CHK({file_rd, discard_fetch, nop_slot, busy, done}, 5'h00)
    t_clear_skip();
    t_clear_pass();
    t_set_skip();
    t_set_indexed();
    t_set_top();
    t_other_opcode();
    finish_test();
  end
endmodule : bts_core_test

// file: bts_decode.sv
// Instruction-word decoder for the two bit-test-skip instructions.
`timescale 1ns/1ps
module bts_decode (
  input  wire logic [15:0]      instr,
  output bts_pkg::bts_dec_t     dec
);
  always_comb begin
    dec.is_test   = (instr[15:12] == bts_pkg::OPC_SKIP_CLEAR) ||
                    (instr[15:12] == bts_pkg::OPC_SKIP_SET);
    dec.want_set  = (instr[15:12] == bts_pkg::OPC_SKIP_SET);
    dec.bit_sel   = instr[11:9];
    dec.bank_sel  = instr[8];
    dec.reg_field = instr[7:0];
  end
endmodule : bts_decode

// file: bts_pkg.sv
// Package with constants and carrier types for the bit-test-skip block.
package bts_pkg;
  localparam logic [3:0] OPC_SKIP_CLEAR = 4'hB;
  localparam logic [3:0] OPC_SKIP_SET   = 4'hA;
  localparam logic [7:0] IDX_OFFSET_MAX = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT   = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam int         QUARTERS       = 4;
  localparam logic [1:0] Q_RESET        = 2'h0;
  localparam logic [1:0] Q_TEST         = 2'h2;
  localparam logic [1:0] Q_LAST         = 2'h3;

  typedef enum logic [1:0] {
    BTS_IDLE    = 2'b00,
    BTS_EXECUTE = 2'b01,
    BTS_SKIP    = 2'b10
  } bts_state_t;

  // Decoded fields of one instruction word.
  typedef struct packed {
    logic       is_test;
    logic       want_set;
    logic [2:0] bit_sel;
    logic       bank_sel;
    logic [7:0] reg_field;
  } bts_dec_t;

  // File-register request toward the data memory.
  typedef struct packed {
    logic        rd;
    logic        indexed;
    logic [11:0] addr;
  } bts_req_t;
endpackage : bts_pkg
